/* File: hw/eep_pkg.sv */
// Shared constants and state codes for the two-wire EEPROM ends
package eep_pkg;
	localparam int ADDR_W = 11;
	localparam int DATA_W = 8;
	localparam int MEM_BYTES = 2048;
	localparam int PAGE_W = 4;
	localparam int PAGE_BYTES = 16;
	localparam int HI_W = ADDR_W - PAGE_W;
	localparam int BLK_LSB = 8;
	localparam int CODE_LSB = 4;
	localparam int CTRL_BLK_LSB = 1;
	localparam int CTRL_RW_BIT = 0;
	localparam logic [3:0] CTRL_CODE = 4'ha;
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [3:0] FIRST_TX_BITS = 4'h1;
	localparam logic [7:0] ERASED_BYTE = 8'hff;
	localparam logic [1:0] Q_LOW = 2'h0;
	localparam logic [1:0] Q_HIGH = 2'h1;
	localparam logic [1:0] Q_SAMPLE = 2'h2;
	localparam logic [1:0] Q_END = 2'h3;
	localparam int CLK_HZ = 40_000_000;
	localparam int T_WC_MS = 5;
	localparam int WC_CYCLES = T_WC_MS * (CLK_HZ / 1000);
	localparam int QUARTER_DEFAULT = 5;
	localparam int LEN_W_DEFAULT = 12;

	typedef enum logic [3:0] {
		DS_IDLE = 4'h0,
		DS_CTRL = 4'h1,
		DS_ACK_CTRL = 4'h2,
		DS_ADDR = 4'h3,
		DS_ACK_ADDR = 4'h4,
		DS_DATA = 4'h5,
		DS_ACK_DATA = 4'h6,
		DS_TX = 4'h7,
		DS_MACK = 4'h8
	} eep_dev_state_t;

	typedef enum logic [3:0] {
		HS_IDLE = 4'h0,
		HS_START = 4'h1,
		HS_CTRL = 4'h2,
		HS_ADDR = 4'h3,
		HS_DATA = 4'h4,
		HS_RSTART = 4'h5,
		HS_RCTRL = 4'h6,
		HS_READ = 4'h7,
		HS_STOP = 4'h8
	} eep_host_state_t;
endpackage

/* File: hw/eep_bus_if.sv */
// Two-wire bus between controller and EEPROM, open-drain data resolved here
interface eep_bus_if;
	logic scl;
	logic host_sda_o;
	logic host_sda_oe;
	logic dev_sda_o;
	logic dev_sda_oe;
	logic sda;

	// Pull-up wins unless some end pulls low
	assign sda = !(host_sda_oe && !host_sda_o) && !(dev_sda_oe && !dev_sda_o);

	modport device(input scl, input sda, output dev_sda_o, output dev_sda_oe);
	modport host(output scl, output host_sda_o, output host_sda_oe, input sda);
endinterface

/* File: hw/eep_dev.sv */
// EEPROM target end: two-wire protocol, page buffer, write cycle, array
// Contract
// - Control byte 1010, block bits, read/write bit
// - Ack write control, next byte loads pointer
// - Up to 16 data bytes held until STOP
// - Page write increments only low nibble
// - Over 16 bytes wraps, newer bytes overwrite
// - Page boundary crossing wraps within page
// - Controller should avoid crossing page boundaries
// - STOP after write starts self-timed commit
// - No acknowledge while write cycle runs
// - Ack polling answered once cycle finishes
// - Write protect high inhibits all programming
// - Write protect low allows full range
// - Read/write bit one starts a read
// - Current read uses last address plus one
// - Ack read control, shift out eight bits
// - Master nack and STOP end read
// - Random read keeps loaded pointer
// - Master ack fetches next sequential byte
// - Pointer increments after each access
// - Supply low disables erase and write
// - Data changes only while clock low
// - Data line open drain, never driven high
// - Hardware select inputs ignored
module eep_dev
	import eep_pkg::*;
#(
	parameter int WRITE_CYCLES = WC_CYCLES
) (
	input wire logic i_clk,
	input wire logic i_reset_n,
	eep_bus_if.device bus,
	input wire logic i_write_protect,
	input wire logic i_supply_low,
	input wire logic [2:0] i_unused_select_inputs,
	output logic o_busy
);
	localparam int WC_W = $clog2(WRITE_CYCLES + 1);
	localparam logic [WC_W-1:0] WC_LOAD = WC_W'(WRITE_CYCLES - 1);

	if (WRITE_CYCLES < 1) begin : g_bad_wc
		$error("WRITE_CYCLES must be at least one");
	end

	typedef struct packed {
		logic [1:0] scl_sync;
		logic [1:0] sda_sync;
		logic [1:0] wp_sync;
		logic [1:0] low_sync;
		logic scl_d;
		logic sda_d;
		eep_dev_state_t st;
		logic [3:0] cnt;
		logic [DATA_W-1:0] sh;
		logic rw;
		logic mack;
		logic [ADDR_W-1:0] ptr;
		logic [PAGE_BYTES-1:0][DATA_W-1:0] page;
		logic [PAGE_BYTES-1:0] mask;
		logic [HI_W-1:0] page_hi;
		logic oe;
		logic busy;
		logic [WC_W-1:0] wc_cnt;
		logic commit;
	} eep_dev_reg_t;

	eep_dev_reg_t r;
	eep_dev_reg_t next_r;
	logic [DATA_W-1:0] mem [MEM_BYTES];
	logic [DATA_W-1:0] rd_byte;
	logic scl_rise;
	logic scl_fall;
	logic start_seen;
	logic stop_seen;

	// Full 11-bit range reachable, nothing blocked by write protect low
	assign rd_byte = mem[r.ptr];
	assign scl_rise = r.scl_sync[1] && !r.scl_d;
	assign scl_fall = !r.scl_sync[1] && r.scl_d;
	// Data edges while clock high are bus conditions, not data
	assign start_seen = r.scl_sync[1] && r.scl_d && r.sda_d && !r.sda_sync[1];
	assign stop_seen = r.scl_sync[1] && r.scl_d && !r.sda_d && r.sda_sync[1];

	assign bus.dev_sda_o = 1'b0;
	assign bus.dev_sda_oe = r.oe;
	assign o_busy = r.busy;

	always_comb begin
		next_r = r;
		next_r.scl_sync = {r.scl_sync[0], bus.scl};
		next_r.sda_sync = {r.sda_sync[0], bus.sda};
		next_r.wp_sync = {r.wp_sync[0], i_write_protect};
		next_r.low_sync = {r.low_sync[0], i_supply_low};
		next_r.scl_d = r.scl_sync[1];
		next_r.sda_d = r.sda_sync[1];
		next_r.commit = 1'b0;
		// Byte mask must survive until the commit pulse has used it
		if (r.commit) begin
			next_r.mask = '0;
		end
		if (r.busy) begin
			if (r.wc_cnt == '0) begin
				next_r.busy = 1'b0;
			end else begin
				next_r.wc_cnt = r.wc_cnt - 1'b1;
			end
		end
		if (start_seen) begin
			// Repeated start drops unsent page data but keeps the pointer
			next_r.st = DS_CTRL;
			next_r.cnt = '0;
			next_r.oe = 1'b0;
			next_r.mask = '0;
		end else if (stop_seen) begin
			if (r.mask != '0 && !r.wp_sync[1] && !r.low_sync[1] && !r.busy) begin
				next_r.commit = 1'b1;
				next_r.busy = 1'b1;
				next_r.wc_cnt = WC_LOAD;
			end else begin
				next_r.mask = '0;
			end
			next_r.st = DS_IDLE;
			next_r.oe = 1'b0;
		end else if (scl_rise) begin
			if (r.st == DS_CTRL || r.st == DS_ADDR || r.st == DS_DATA) begin
				next_r.sh = {r.sh[DATA_W-2:0], r.sda_sync[1]};
				next_r.cnt = r.cnt + 1'b1;
			end else if (r.st == DS_MACK) begin
				next_r.mack = r.sda_sync[1];
			end
		end else if (scl_fall) begin
			unique case (r.st)
				DS_IDLE: begin
				end
				DS_CTRL: begin
					if (r.cnt == BYTE_BITS) begin
						next_r.cnt = '0;
						// Selection by control code while not busy, pins play no part
						if (r.sh[DATA_W-1:CODE_LSB] == CTRL_CODE && !r.busy) begin
							next_r.oe = 1'b1;
							next_r.rw = r.sh[CTRL_RW_BIT];
							next_r.ptr[ADDR_W-1:BLK_LSB] = r.sh[CODE_LSB-1:CTRL_BLK_LSB];
							next_r.mask = '0;
							next_r.st = DS_ACK_CTRL;
						end else begin
							next_r.st = DS_IDLE;
						end
					end
				end
				DS_ACK_CTRL: begin
					if (r.rw) begin
						next_r.sh = rd_byte;
						next_r.oe = !rd_byte[DATA_W-1];
						next_r.cnt = FIRST_TX_BITS;
						next_r.st = DS_TX;
					end else begin
						next_r.oe = 1'b0;
						next_r.cnt = '0;
						next_r.st = DS_ADDR;
					end
				end
				DS_ADDR: begin
					if (r.cnt == BYTE_BITS) begin
						next_r.cnt = '0;
						next_r.ptr[BLK_LSB-1:0] = r.sh;
						next_r.page_hi = {r.ptr[ADDR_W-1:BLK_LSB], r.sh[DATA_W-1:PAGE_W]};
						next_r.oe = 1'b1;
						next_r.st = DS_ACK_ADDR;
					end
				end
				DS_ACK_ADDR, DS_ACK_DATA: begin
					next_r.oe = 1'b0;
					next_r.cnt = '0;
					next_r.st = DS_DATA;
				end
				DS_DATA: begin
					if (r.cnt == BYTE_BITS) begin
						next_r.cnt = '0;
						// Index wraps inside the page, later bytes overwrite
						next_r.page[r.ptr[PAGE_W-1:0]] = r.sh;
						next_r.mask[r.ptr[PAGE_W-1:0]] = 1'b1;
						next_r.ptr[PAGE_W-1:0] = r.ptr[PAGE_W-1:0] + 1'b1;
						next_r.oe = 1'b1;
						next_r.st = DS_ACK_DATA;
					end
				end
				DS_TX: begin
					if (r.cnt == BYTE_BITS) begin
						next_r.oe = 1'b0;
						next_r.ptr = r.ptr + 1'b1;
						next_r.st = DS_MACK;
					end else begin
						next_r.sh = {r.sh[DATA_W-2:0], 1'b0};
						next_r.oe = !r.sh[DATA_W-2];
						next_r.cnt = r.cnt + 1'b1;
					end
				end
				DS_MACK: begin
					if (!r.mack) begin
						next_r.sh = rd_byte;
						next_r.oe = !rd_byte[DATA_W-1];
						next_r.cnt = FIRST_TX_BITS;
						next_r.st = DS_TX;
					end else begin
						next_r.st = DS_IDLE;
					end
				end
				default: begin
					next_r.oe = 1'b0;
					next_r.st = DS_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			r <= '0;
			r.scl_sync <= 2'h3;
			r.sda_sync <= 2'h3;
			r.scl_d <= 1'b1;
			r.sda_d <= 1'b1;
			r.st <= DS_IDLE;
		end else begin
			r <= next_r;
		end
	end

	// Array starts erased; commit writes only bytes that arrived
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			for (int i = 0; i < MEM_BYTES; i++) begin
				mem[i] <= ERASED_BYTE;
			end
		end else if (r.commit) begin
			for (int i = 0; i < PAGE_BYTES; i++) begin
				if (r.mask[i]) begin
					mem[{r.page_hi, PAGE_W'(i)}] <= r.page[i];
				end
			end
		end
	end
endmodule

/* File: hw/eep_host.sv */
// Bus controller end with write-data FIFO, clock divider and polling retry
module eep_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic i_valid,
	output logic o_ready,
	input wire logic [WIDTH-1:0] i_data,
	output logic o_valid,
	input wire logic i_ready,
	output logic [WIDTH-1:0] o_data
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [PW:0] FULL_CNT = (PW + 1)'(DEPTH);

	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad_fifo
		$error("FIFO depth must be a power of two of at least two");
	end

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PW-1:0] wp;
		logic [PW-1:0] rp;
		logic [PW:0] cnt;
		logic full;
		logic nonempty;
	} eep_fifo_reg_t;

	eep_fifo_reg_t r;
	eep_fifo_reg_t next_r;
	logic push;
	logic pop;
	logic [PW:0] cnt_n;

	assign push = i_valid && !r.full;
	assign pop = i_ready && r.nonempty;
	assign o_ready = !r.full;
	assign o_valid = r.nonempty;
	assign o_data = r.mem[r.rp];

	always_comb begin
		next_r = r;
		cnt_n = r.cnt;
		if (push) begin
			next_r.mem[r.wp] = i_data;
			next_r.wp = r.wp + 1'b1;
			cnt_n = cnt_n + 1'b1;
		end
		if (pop) begin
			next_r.rp = r.rp + 1'b1;
			cnt_n = cnt_n - 1'b1;
		end
		next_r.cnt = cnt_n;
		next_r.full = (cnt_n == FULL_CNT);
		next_r.nonempty = (cnt_n != '0);
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end
endmodule

module eep_host
	import eep_pkg::*;
#(
	parameter int QUARTER_CYCLES = QUARTER_DEFAULT,
	parameter int LEN_W = LEN_W_DEFAULT,
	parameter int FIFO_DEPTH = 8
) (
	input wire logic i_clk,
	input wire logic i_reset_n,
	eep_bus_if.host bus,
	input wire logic i_cmd_valid,
	output logic o_cmd_ready,
	input wire logic i_cmd_read,
	input wire logic [ADDR_W-1:0] i_cmd_addr,
	input wire logic [LEN_W-1:0] i_cmd_len,
	input wire logic i_wr_valid,
	output logic o_wr_ready,
	input wire logic [DATA_W-1:0] i_wr_data,
	output logic o_rd_valid,
	output logic [DATA_W-1:0] o_rd_data,
	output logic o_done
);
	localparam int QW = $clog2(QUARTER_CYCLES + 1);
	localparam logic [QW-1:0] Q_LOAD = QW'(QUARTER_CYCLES - 1);

	if (QUARTER_CYCLES < 4 || LEN_W < 1) begin : g_bad_host
		$error("QUARTER_CYCLES must be at least four");
	end

	typedef struct packed {
		logic [1:0] sda_sync;
		eep_host_state_t st;
		logic [1:0] q;
		logic [QW-1:0] qcnt;
		logic [3:0] bitn;
		logic [DATA_W-1:0] sh;
		logic scl;
		logic oe;
		logic rd;
		logic retry;
		logic got;
		logic [ADDR_W-1:0] addr;
		logic [LEN_W-1:0] left;
		logic ready;
		logic rd_valid;
		logic [DATA_W-1:0] rd_data;
		logic done;
	} eep_host_reg_t;

	eep_host_reg_t r;
	eep_host_reg_t next_r;
	logic f_valid;
	logic [DATA_W-1:0] f_data;
	logic tick;
	logic stall;
	logic pop;
	logic sending;

	assign tick = (r.qcnt == '0) && (r.st != HS_IDLE);
	// Empty FIFO holds the clock low before a data byte
	assign stall = (r.st == HS_DATA) && (r.bitn == '0) && (r.q == Q_LOW) && !f_valid;
	assign pop = tick && (r.st == HS_DATA) && (r.bitn == '0) && (r.q == Q_LOW) && f_valid;
	assign sending = (r.st == HS_CTRL) || (r.st == HS_ADDR) || (r.st == HS_DATA)
		|| (r.st == HS_RCTRL);

	eep_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_wr_fifo (
		.i_clk(i_clk),
		.i_reset_n(i_reset_n),
		.i_valid(i_wr_valid),
		.o_ready(o_wr_ready),
		.i_data(i_wr_data),
		.o_valid(f_valid),
		.i_ready(pop),
		.o_data(f_data)
	);

	assign bus.scl = r.scl;
	assign bus.host_sda_o = 1'b0;
	assign bus.host_sda_oe = r.oe;
	assign o_cmd_ready = r.ready;
	assign o_rd_valid = r.rd_valid;
	assign o_rd_data = r.rd_data;
	assign o_done = r.done;

	always_comb begin
		next_r = r;
		next_r.sda_sync = {r.sda_sync[0], bus.sda};
		next_r.rd_valid = 1'b0;
		next_r.done = 1'b0;
		if (r.st == HS_IDLE) begin
			if (i_cmd_valid && r.ready && !(i_cmd_read && i_cmd_len == '0)) begin
				next_r.ready = 1'b0;
				next_r.rd = i_cmd_read;
				next_r.addr = i_cmd_addr;
				next_r.left = i_cmd_len;
				next_r.st = HS_START;
				next_r.q = Q_LOW;
				next_r.bitn = '0;
				next_r.qcnt = Q_LOAD;
			end
		end else if (!tick) begin
			next_r.qcnt = r.qcnt - 1'b1;
		end else if (!stall) begin
			next_r.qcnt = Q_LOAD;
			next_r.q = r.q + 1'b1;
			unique case (r.q)
				Q_LOW: begin
					next_r.scl = 1'b0;
					if (r.st == HS_START || r.st == HS_RSTART) begin
						next_r.oe = 1'b0;
					end else if (r.st == HS_STOP) begin
						next_r.oe = 1'b1;
					end else if (pop) begin
						next_r.sh = f_data;
						next_r.oe = !f_data[DATA_W-1];
					end else if (sending) begin
						next_r.oe = (r.bitn != BYTE_BITS) && !r.sh[DATA_W-1];
					end else begin
						// Ack every byte but the last of a read
						next_r.oe = (r.bitn == BYTE_BITS) && (r.left != 1);
					end
				end
				Q_HIGH: begin
					next_r.scl = 1'b1;
				end
				Q_SAMPLE: begin
					if (r.st == HS_START || r.st == HS_RSTART) begin
						next_r.oe = 1'b1;
					end else if (r.st == HS_STOP) begin
						next_r.oe = 1'b0;
					end else if (sending && r.bitn == BYTE_BITS) begin
						next_r.got = r.sda_sync[1];
					end else if (r.st == HS_READ && r.bitn != BYTE_BITS) begin
						next_r.sh = {r.sh[DATA_W-2:0], r.sda_sync[1]};
					end
				end
				Q_END: begin
					next_r.scl = (r.st == HS_STOP);
					next_r.bitn = '0;
					unique case (r.st)
						HS_START: begin
							next_r.sh = {CTRL_CODE, r.addr[ADDR_W-1:BLK_LSB], 1'b0};
							next_r.st = HS_CTRL;
						end
						HS_RSTART: begin
							next_r.sh = {CTRL_CODE, r.addr[ADDR_W-1:BLK_LSB], 1'b1};
							next_r.st = HS_RCTRL;
						end
						HS_STOP: begin
							if (r.retry) begin
								next_r.retry = 1'b0;
								next_r.st = HS_START;
							end else begin
								next_r.st = HS_IDLE;
								next_r.ready = 1'b1;
								next_r.done = 1'b1;
							end
						end
						default: begin
							if (r.bitn != BYTE_BITS) begin
								next_r.bitn = r.bitn + 1'b1;
								if (sending) begin
									next_r.sh = {r.sh[DATA_W-2:0], 1'b0};
								end
							end else if ((r.st == HS_CTRL || r.st == HS_RCTRL) && r.got) begin
								// Busy device: stop and poll again
								next_r.retry = 1'b1;
								next_r.st = HS_STOP;
							end else if (r.st == HS_CTRL) begin
								next_r.sh = r.addr[BLK_LSB-1:0];
								next_r.st = HS_ADDR;
							end else if (r.st == HS_ADDR) begin
								next_r.st = r.rd ? HS_RSTART :
									((r.left == '0 || r.got) ? HS_STOP : HS_DATA);
							end else if (r.st == HS_RCTRL) begin
								next_r.st = HS_READ;
							end else begin
								if (r.st == HS_READ) begin
									next_r.rd_valid = 1'b1;
									next_r.rd_data = r.sh;
								end
								next_r.left = r.left - 1'b1;
								next_r.st = (r.left == 1 || (r.st == HS_DATA && r.got))
									? HS_STOP : r.st;
							end
						end
					endcase
				end
			endcase
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			r <= '0;
			r.sda_sync <= 2'h3;
			r.st <= HS_IDLE;
			r.scl <= 1'b1;
			r.ready <= 1'b1;
		end else begin
			r <= next_r;
		end
	end
endmodule

/* File: test/eep_link_monitor.sv */
// Checker on the two-wire link between the host and EEPROM ends
module eep_link_monitor #(
	parameter int WRITE_CYCLES = 50
) (
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic scl,
	input wire logic sda,
	input wire logic dev_sda_o,
	input wire logic dev_sda_oe,
	input wire logic o_busy
);
	int busy_len;
	int stop_age;
	logic [3:0] bits;
	logic [7:0] ctrl;

	// Busy length, cycles since STOP, clock rises since START, first byte
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			busy_len <= 0;
			stop_age <= 255;
			bits <= 4'hf;
			ctrl <= 8'h00;
		end else begin
			busy_len <= o_busy ? busy_len + 1 : 0;
			if (scl && $rose(sda)) begin
				stop_age <= 0;
			end else if (stop_age < 255) begin
				stop_age <= stop_age + 1;
			end
			if (scl && $fell(sda)) begin
				bits <= 4'h0;
			end else if ($rose(scl) && bits != 4'hf) begin
				bits <= bits + 4'h1;
			end
			if ($rose(scl) && bits < 4'h8) begin
				ctrl <= {ctrl[6:0], sda};
			end
		end
	end

	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);

	dev_open_drain_a: assert property (dev_sda_oe |-> !dev_sda_o)
		else $error("device drove the data line high");
	dev_stable_high_a: assert property (scl && $past(scl) |-> $stable(dev_sda_oe))
		else $error("device data changed while clock high");
	busy_silent_a: assert property (o_busy |-> !dev_sda_oe)
		else $error("device pulled data low while busy");
	busy_after_stop_a: assert property ($rose(o_busy) |-> stop_age <= 12)
		else $error("write cycle started without a STOP");
	busy_span_a: assert property ($fell(o_busy) |-> busy_len inside {[WRITE_CYCLES-1:WRITE_CYCLES+1]})
		else $error("write cycle length wrong");
	busy_bound_a: assert property (o_busy |-> busy_len <= WRITE_CYCLES + 1)
		else $error("write cycle did not expire");
	ack_after_byte_a: assert property ($rose(dev_sda_oe) |-> bits >= 4'h8)
		else $error("device drove data before a full byte");
	ctrl_code_a: assert property ($rose(dev_sda_oe) && bits == 4'h8 |-> ctrl[7:4] == 4'ha)
		else $error("device answered a foreign control code");
endmodule

/* File: test/serial_eeprom_i2c_slave_bench.sv */
// Bench joining host and EEPROM ends over the two-wire link
module serial_eeprom_i2c_slave_bench
	import eep_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// Longer than a control byte, so acknowledge polling really happens
	localparam int WCYC = 600;
	logic i_clk = 1'b0;
	logic i_reset_n = 1'b0;
	logic cmd_valid = 1'b0;
	logic cmd_read = 1'b0;
	logic [ADDR_W-1:0] cmd_addr = '0;
	logic [LEN_W_DEFAULT-1:0] cmd_len = '0;
	logic wr_valid = 1'b0;
	logic [DATA_W-1:0] wr_data = 8'h00;
	logic wp = 1'b0;
	logic low = 1'b0;
	logic [2:0] sel = 3'h0;
	logic cmd_ready;
	logic wr_ready;
	logic rd_valid;
	logic [DATA_W-1:0] rd_data;
	logic done;
	logic busy;
	logic [7:0] mem [MEM_BYTES];
	int error_cnt = 0;
	int tests_run = 0;
	int busy_cycles = 0;
	int b0;

	eep_bus_if eep_bus_if_i();
	eep_dev #(.WRITE_CYCLES(WCYC)) eep_dev_i (.i_clk(i_clk), .i_reset_n(i_reset_n),
		.bus(eep_bus_if_i), .i_write_protect(wp), .i_supply_low(low),
		.i_unused_select_inputs(sel), .o_busy(busy));
	eep_host eep_host_i (.i_clk(i_clk), .i_reset_n(i_reset_n), .bus(eep_bus_if_i),
		.i_cmd_valid(cmd_valid), .o_cmd_ready(cmd_ready), .i_cmd_read(cmd_read),
		.i_cmd_addr(cmd_addr), .i_cmd_len(cmd_len), .i_wr_valid(wr_valid),
		.o_wr_ready(wr_ready), .i_wr_data(wr_data), .o_rd_valid(rd_valid),
		.o_rd_data(rd_data), .o_done(done));
	eep_link_monitor #(.WRITE_CYCLES(WCYC)) eep_link_monitor_i (.i_clk(i_clk),
		.i_reset_n(i_reset_n), .scl(eep_bus_if_i.scl), .sda(eep_bus_if_i.sda),
		.dev_sda_o(eep_bus_if_i.dev_sda_o), .dev_sda_oe(eep_bus_if_i.dev_sda_oe),
		.o_busy(busy));

	initial begin
		forever #12.5 i_clk = ~i_clk;
	end

	always @(posedge i_clk) begin
		if (busy === 1'b1) busy_cycles++;
	end

	task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wrap_up();
		if (error_cnt == 0 && tests_run > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic push(logic [7:0] d);
		@(negedge i_clk);
		wr_valid = 1'b1;
		wr_data = d;
		@(posedge i_clk);
		for (int n = 0; n < 20000 && wr_ready !== 1'b1; n++) @(posedge i_clk);
		@(negedge i_clk);
		wr_valid = 1'b0;
	endtask

	// One command; reads are compared with the model
	task automatic run(logic rd, logic [10:0] a, int n);
		logic [7:0] q [$];
		int t;
		@(negedge i_clk);
		cmd_valid = 1'b1;
		cmd_read = rd;
		cmd_addr = a;
		cmd_len = 12'(n);
		@(posedge i_clk);
		for (int k = 0; k < 100 && cmd_ready !== 1'b1; k++) @(posedge i_clk);
		@(negedge i_clk);
		cmd_valid = 1'b0;
		for (t = 0; t < 40000 && done !== 1'b1; t++) begin
			@(posedge i_clk);
			if (rd_valid === 1'b1) q.push_back(rd_data);
		end
		check("command done", 8'(t < 40000), 8'h01);
		if (rd) begin
			check("read count", 8'(q.size()), 8'(n));
			for (int k = 0; k < n; k++) check("read byte", q[k], mem[11'(a + k)]);
		end
	endtask

	// Page write; model keeps the upper bits and wraps the low nibble
	task automatic wr(logic [10:0] a, int n, logic [7:0] base);
		fork
			for (int k = 0; k < n; k++) push(base + 8'(k));
			run(1'b0, a, n);
		join
		for (int k = 0; k < n && !wp && !low; k++) begin
			mem[{a[10:4], 4'(a[3:0] + k)}] = base + 8'(k);
		end
	endtask

	initial begin
		foreach (mem[k]) mem[k] = ERASED_BYTE;
		repeat (2) @(posedge i_clk);
		@(negedge i_clk);
		i_reset_n = 1'b1;
		check("busy after reset", busy, 1'b0);
		for (int k = 0; k < 8; k++) push(8'h10 + 8'(k));
		check("fifo full", wr_ready, 1'b0);
		b0 = busy_cycles;
		run(1'b0, 11'h3f8, 8);
		for (int k = 0; k < 8; k++) mem[11'h3f8 + k] = 8'h10 + 8'(k);
		run(1'b1, 11'h3f8, 8);
		check("write cycle", 8'(busy_cycles - b0 inside {[WCYC-1:WCYC+1]}), 8'h01);
		@(negedge i_clk);
		sel = 3'h7;
		wr(11'h125, 20, 8'h80);
		run(1'b1, 11'h120, 16);
		wr(11'h7ff, 1, 8'h5a);
		run(1'b1, 11'h7fe, 4);
		run(1'b1, 11'h12a, 1);
		wr(11'h200, 1, 8'h33);
		wr(11'h201, 1, 8'h44);
		run(1'b1, 11'h200, 2);
		for (int m = 0; m < 2; m++) begin
			@(negedge i_clk);
			wp = (m == 0);
			low = (m == 1);
			sel = 3'(m);
			b0 = busy_cycles;
			wr(11'h040, 2, 8'hc0);
			run(1'b1, 11'h040, 2);
			check("no write cycle", 8'(busy_cycles - b0), 8'h00);
		end
		wrap_up();
	end

	initial begin
		#(25 * 80000);
		error_cnt++;
		wrap_up();
	end
endmodule
